/* File: dfs_lane.sv */
// One serial data lane: loads a word and shifts it out MSB first
`timescale 1ns/10ps
module dfs_lane #(
  parameter int W = 36,
  parameter int NBW = 6
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [W-1:0] word_i,
  input wire logic [NBW-1:0] nbits_i,
  output logic bit_o
);

  typedef struct packed {
    logic [W-1:0] sh;
    logic [NBW-1:0] cnt;
    logic bit_out;
  } dfs_lane_st_t;

  dfs_lane_st_t s_q;
  dfs_lane_st_t s_d;

  always_comb begin
    s_d = s_q;
    if (load_i) begin
      s_d.bit_out = word_i[W-1];
      s_d.sh = {word_i[W-2:0], 1'b0};
      s_d.cnt = nbits_i - NBW'(1);
    end else if (s_q.cnt != '0) begin
      s_d.bit_out = s_q.sh[W-1];
      s_d.sh = {s_q.sh[W-2:0], 1'b0};
      s_d.cnt = s_q.cnt - NBW'(1);
    end else begin
      s_d.bit_out = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bit_o = s_q.bit_out;

endmodule

/* File: dfs_pkg.sv */
// Shared constants and carrier types for the decimation and serial output block
package dfs_pkg;

  // Register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_NCO_FREQ = 12'h004;
  localparam logic [11:0] OFS_NCO_ACTIVE = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00c;

  // Control register field positions
  localparam int CTRL_DECIM_EN = 0;
  localparam int CTRL_REAL_MODE = 1;
  localparam int CTRL_RATIO_LO = 2;
  localparam int CTRL_GAIN_EN = 5;
  localparam int CTRL_SYNC_EN = 6;
  localparam int CTRL_SW_SYNC = 8;
  localparam int CTRL_MIX_RESTART = 9;

  // Status register field positions
  localparam int STAT_DIV_LO = 0;
  localparam int STAT_SYNC_CNT_LO = 8;
  localparam int STAT_BUSY = 16;

  // Ratio select: 0..4 gives 2,4,8,16,32
  localparam logic [2:0] RATIO_SEL_MAX = 3'h4;
  localparam int RATIO_MAX = 32;
  localparam int RESYNC_STEP = 64;

  // Gain constants: 6 dB is a one-bit shift, 3 dB is 181/128
  localparam logic signed [8:0] GAIN_3DB_MUL = 9'h0b5;
  localparam int GAIN_3DB_SHIFT = 7;
  localparam int WORK_W = 20;
  localparam int ACC_W = 24;
  localparam int SAMPLE_W = 18;

  // Reset values
  localparam logic [31:0] NCO_RST = 32'h0000_0000;
  localparam logic [4:0] DIV_RST = 5'h00;
  localparam logic [7:0] SYNC_CNT_RST = 8'h00;

  typedef struct packed {
    logic [11:0] paddr;
    logic pwrite;
    logic [31:0] pwdata;
    logic psel;
    logic penable;
  } dfs_apb_req_t;

  typedef struct packed {
    logic gain_en;
    logic sync_en;
    logic [2:0] ratio_sel;
    logic real_mode;
    logic decim_en;
  } dfs_ctrl_t;

  localparam dfs_ctrl_t CTRL_RST = 7'h00;

  function automatic logic [WORK_W-1:0] dfs_sat(input logic signed [ACC_W-1:0] v);
    logic signed [ACC_W-1:0] hi;
    logic signed [ACC_W-1:0] lo;
    hi = ACC_W'((1 <<< (WORK_W - 1)) - 1);
    lo = -ACC_W'(1 <<< (WORK_W - 1));
    if (v > hi) begin
      dfs_sat = hi[WORK_W-1:0];
    end else if (v < lo) begin
      dfs_sat = lo[WORK_W-1:0];
    end else begin
      dfs_sat = v[WORK_W-1:0];
    end
  endfunction

endpackage

/* File: dfs_rx_model.sv */
// Receiving-side model: captures one frame from the serial lanes
`timescale 1ns/10ps
module dfs_rx_model #(
  parameter int NB = 18
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [1:0] serial_data_lanes_i,
  input wire logic frame_clock_i,
  output logic [35:0] word_o,
  output logic word_valid_o,
  output int period_o
);
  logic frame_clock_out_q;
  int cnt;
  int cyc;
  int last;
  always @(posedge core_clk_i) begin
    word_valid_o <= 1'b0;
    frame_clock_out_q <= frame_clock_i;
    cyc <= cyc + 1;
    if (rst_i) begin
      cnt <= 0;
      cyc <= 0;
      last <= 0;
      word_o <= '0;
    end else if (frame_clock_i && !frame_clock_out_q) begin
      cnt <= 1;
      word_o <= {34'h0_0000_0000, serial_data_lanes_i[0], serial_data_lanes_i[1]};
      period_o <= cyc - last;
      last <= cyc;
    end else if (cnt > 0 && cnt < NB) begin
      // Lane 0 holds the earlier bit of each pair, so MSB lands first
      word_o <= {word_o[33:0], serial_data_lanes_i[0], serial_data_lanes_i[1]};
      cnt <= cnt + 1;
      word_valid_o <= (cnt == NB - 1);
    end else begin
      cnt <= 0;
    end
  end
endmodule

/* File: dfs_top.sv */
// Mixer, decimator, sync handling and serial framing with APB registers
`timescale 1ns/10ps
// Operation
// - Complex decimation by 2, 4, 8, 16 or 32; output rate is Fs over ratio.
// - Filter should reject stop bands 85 dB and pass about 80 percent; the code uses a plain boxcar average instead.
// - Real mode passband is half the complex one, 0.4 Fs over ratio.
// - Complex output is Fs/N pairs with Nyquist zone Fs/(2N).
// - Power-down pin becomes sync input when sync enable set; sampled on clock.
// - Sync comes from the pin or a software bit; needed only when decimating.
// - Sync resets decimation dividers so I and Q come from one sample.
// - Without sync the dividers run from whatever phase they hold.
// - Sync clears oscillator phase and loads new frequency, like mixer restart.
// - Complex lane rate Fs*2R/(L*N); frame Fs/N; bit clock half lane rate.
// - Real lane rate Fs*R/(L*M); frame Fs/2M for two lanes, else Fs/M.
// - New oscillator word takes effect only after restart bit or sync.
// - Oscillator word is 32-bit signed, f times 2^32 over Fs.
// - Optional gain: 6 dB in complex mode, 3 dB in real mode.
module dfs_top #(
  parameter int RES = 18,
  parameter int LANES = 2
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire dfs_pkg::dfs_apb_req_t apb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic signed [dfs_pkg::SAMPLE_W-1:0] sample_i,
  input wire logic sample_valid_i,
  input wire logic powerdown_or_sync_pin_i,
  output logic powerdown_o,
  output logic [LANES-1:0] serial_data_lanes_o,
  output logic serial_bit_clock_out_o,
  output logic frame_clock_out_o
);

  localparam int FW = 2 * RES;
  localparam int NBW = $clog2(FW + 1);
  localparam int LW = FW / LANES;

  generate
    if (LANES < 1 || LANES > 2 || RES < 14 || RES > dfs_pkg::WORK_W || (RES % 2) != 0) begin : g_bad
      $error("dfs_top: unsupported RES or LANES");
    end
    if ((2 << dfs_pkg::RATIO_SEL_MAX) != dfs_pkg::RATIO_MAX) begin : g_bad_ratio
      $error("dfs_top: divider width does not match ratio range");
    end
  endgenerate

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    dfs_pkg::dfs_ctrl_t ctrl;
    logic [31:0] nco_pend;
    logic [31:0] nco_act;
    logic [31:0] phase;
    logic [2:0] pin_sync;
    logic pin_lvl;
    logic pwrdn;
    logic [4:0] div;
    logic signed [dfs_pkg::ACC_W-1:0] acc_i;
    logic signed [dfs_pkg::ACC_W-1:0] acc_q;
    logic [RES-1:0] held;
    logic half;
    logic [7:0] sync_cnt;
    logic [FW-1:0] frame;
    logic [NBW-1:0] nbits;
    logic load;
    logic bclk;
    logic frame_clock_out;
    logic [NBW-1:0] fcnt;
  } dfs_st_t;

  dfs_st_t s_q;
  dfs_st_t s_d;

  logic acc_phase;
  logic wr_acc;
  logic [31:0] rdata;
  logic unmapped;
  logic sw_sync;
  logic mix_restart;
  logic pin_agree;
  logic pin_rise;
  logic sync_ev;
  logic restart;
  logic [2:0] sel;
  logic [4:0] div_last;
  logic signed [dfs_pkg::SAMPLE_W:0] mi;
  logic signed [dfs_pkg::SAMPLE_W:0] mq;
  logic signed [dfs_pkg::ACC_W-1:0] sum_i;
  logic signed [dfs_pkg::ACC_W-1:0] sum_q;
  logic signed [dfs_pkg::ACC_W-1:0] avg_i;
  logic signed [dfs_pkg::ACC_W-1:0] avg_q;
  logic [dfs_pkg::WORK_W-1:0] out_i;
  logic [dfs_pkg::WORK_W-1:0] out_q;
  logic [LANES-1:0][LW-1:0] lane_word;
  logic [LANES-1:0] lane_bit;

  // Gain stage; real mode uses a fixed-point root two
  function automatic logic signed [dfs_pkg::ACC_W-1:0] dfs_gain(
    input logic signed [dfs_pkg::ACC_W-1:0] v,
    input logic en,
    input logic real_mode
  );
    logic signed [dfs_pkg::ACC_W+8:0] prod;
    prod = v * dfs_pkg::GAIN_3DB_MUL;
    if (!en) begin
      dfs_gain = v;
    end else if (real_mode) begin
      dfs_gain = dfs_pkg::ACC_W'(prod >>> dfs_pkg::GAIN_3DB_SHIFT);
    end else begin
      dfs_gain = v <<< 1;
    end
  endfunction

  always_comb begin
    acc_phase = apb_i.psel && apb_i.penable;
    wr_acc = acc_phase && s_q.pready && apb_i.pwrite;
    unmapped = 1'b0;
    rdata = 32'h0000_0000;
    case (apb_i.paddr)
      dfs_pkg::OFS_CTRL: begin
        rdata[dfs_pkg::CTRL_DECIM_EN] = s_q.ctrl.decim_en;
        rdata[dfs_pkg::CTRL_REAL_MODE] = s_q.ctrl.real_mode;
        rdata[dfs_pkg::CTRL_RATIO_LO +: 3] = s_q.ctrl.ratio_sel;
        rdata[dfs_pkg::CTRL_GAIN_EN] = s_q.ctrl.gain_en;
        rdata[dfs_pkg::CTRL_SYNC_EN] = s_q.ctrl.sync_en;
      end
      dfs_pkg::OFS_NCO_FREQ: begin
        rdata = s_q.nco_pend;
      end
      dfs_pkg::OFS_NCO_ACTIVE: begin
        rdata = s_q.nco_act;
      end
      dfs_pkg::OFS_STATUS: begin
        rdata[dfs_pkg::STAT_DIV_LO +: 5] = s_q.div;
        rdata[dfs_pkg::STAT_SYNC_CNT_LO +: 8] = s_q.sync_cnt;
        rdata[dfs_pkg::STAT_BUSY] = (s_q.fcnt != '0);
      end
      default: begin
        unmapped = 1'b1;
      end
    endcase
    // Strobe bits act only on a completed write to the control word
    sw_sync = wr_acc && !unmapped && (apb_i.paddr == dfs_pkg::OFS_CTRL)
              && apb_i.pwdata[dfs_pkg::CTRL_SW_SYNC];
    mix_restart = wr_acc && !unmapped && (apb_i.paddr == dfs_pkg::OFS_CTRL)
                  && apb_i.pwdata[dfs_pkg::CTRL_MIX_RESTART];
    // Second and third stages must agree before the pin level changes
    pin_agree = (s_q.pin_sync[1] == s_q.pin_sync[2]);
    pin_rise = pin_agree && s_q.pin_sync[2] && !s_q.pin_lvl;
    sync_ev = (s_q.ctrl.sync_en && pin_rise) || sw_sync;
    restart = sync_ev || mix_restart;
    // Selects above the top setting clamp to the largest ratio
    sel = (s_q.ctrl.ratio_sel > dfs_pkg::RATIO_SEL_MAX) ? dfs_pkg::RATIO_SEL_MAX
          : s_q.ctrl.ratio_sel;
    div_last = s_q.ctrl.decim_en ? 5'((6'h02 << sel) - 6'h01) : 5'h00;
    // Coarse quadrature oscillator from the top phase bits
    case (s_q.phase[31:30])
      2'b00: begin
        mi = 19'(sample_i);
        mq = 19'h0_0000;
      end
      2'b01: begin
        mi = 19'h0_0000;
        mq = 19'(sample_i);
      end
      2'b10: begin
        mi = -19'(sample_i);
        mq = 19'h0_0000;
      end
      default: begin
        mi = 19'h0_0000;
        mq = -19'(sample_i);
      end
    endcase
    // Real mode and bypass skip the mixer entirely
    if (s_q.ctrl.real_mode || !s_q.ctrl.decim_en) begin
      mi = 19'(sample_i);
      mq = 19'h0_0000;
    end
    sum_i = s_q.acc_i + dfs_pkg::ACC_W'(mi);
    sum_q = s_q.acc_q + dfs_pkg::ACC_W'(mq);
    // Boxcar average; stop-band depth is limited by this structure
    avg_i = s_q.ctrl.decim_en ? (sum_i >>> (sel + 3'h1)) : sum_i;
    avg_q = s_q.ctrl.decim_en ? (sum_q >>> (sel + 3'h1)) : sum_q;
    out_i = dfs_pkg::dfs_sat(dfs_gain(avg_i <<< 1, s_q.ctrl.gain_en, s_q.ctrl.real_mode));
    out_q = dfs_pkg::dfs_sat(dfs_gain(avg_q <<< 1, s_q.ctrl.gain_en, s_q.ctrl.real_mode));

    s_d = s_q;
    s_d.load = 1'b0;

    // APB slave with one wait state
    if (acc_phase && !s_q.pready) begin
      s_d.pready = 1'b1;
      s_d.prdata = apb_i.pwrite ? 32'h0000_0000 : rdata;
      s_d.pslverr = unmapped;
    end else begin
      s_d.pready = 1'b0;
      s_d.pslverr = 1'b0;
    end
    if (wr_acc && !unmapped) begin
      case (apb_i.paddr)
        dfs_pkg::OFS_CTRL: begin
          s_d.ctrl.decim_en = apb_i.pwdata[dfs_pkg::CTRL_DECIM_EN];
          s_d.ctrl.real_mode = apb_i.pwdata[dfs_pkg::CTRL_REAL_MODE];
          s_d.ctrl.ratio_sel = apb_i.pwdata[dfs_pkg::CTRL_RATIO_LO +: 3];
          s_d.ctrl.gain_en = apb_i.pwdata[dfs_pkg::CTRL_GAIN_EN];
          s_d.ctrl.sync_en = apb_i.pwdata[dfs_pkg::CTRL_SYNC_EN];
        end
        dfs_pkg::OFS_NCO_FREQ: begin
          s_d.nco_pend = apb_i.pwdata;
        end
        default: begin
        end
      endcase
    end

    // Pin synchroniser; level without sync enable is the power-down request
    // Rising edge only, so a pin held high syncs once
    s_d.pin_sync = {s_q.pin_sync[1:0], powerdown_or_sync_pin_i};
    if (pin_agree) begin
      s_d.pin_lvl = s_q.pin_sync[2];
    end
    s_d.pwrdn = !s_q.ctrl.sync_en && s_q.pin_lvl;

    // Oscillator: new word only through a restart
    if (restart) begin
      s_d.phase = dfs_pkg::NCO_RST;
      s_d.nco_act = s_q.nco_pend;
    end else if (sample_valid_i) begin
      s_d.phase = s_q.phase + s_q.nco_act;
    end

    if (sync_ev) begin
      // Restart dividers so both rails start on the same sample
      s_d.div = dfs_pkg::DIV_RST;
      s_d.acc_i = '0;
      s_d.acc_q = '0;
      s_d.half = 1'b0;
      s_d.sync_cnt = s_q.sync_cnt + 8'h01;
    end else if (sample_valid_i) begin
      // Divider free-runs from its current phase when never synced
      if (s_q.div >= div_last) begin
        s_d.div = dfs_pkg::DIV_RST;
        s_d.acc_i = '0;
        s_d.acc_q = '0;
        if (s_q.ctrl.decim_en && !s_q.ctrl.real_mode) begin
          s_d.frame = {out_i[dfs_pkg::WORK_W-1 -: RES], out_q[dfs_pkg::WORK_W-1 -: RES]};
          s_d.nbits = NBW'(FW / LANES);
          s_d.load = 1'b1;
        end else if (LANES == 2 && !s_q.half) begin
          s_d.held = out_i[dfs_pkg::WORK_W-1 -: RES];
          s_d.half = 1'b1;
        end else if (LANES == 2) begin
          s_d.frame = {s_q.held, out_i[dfs_pkg::WORK_W-1 -: RES]};
          s_d.nbits = NBW'(RES);
          s_d.half = 1'b0;
          s_d.load = 1'b1;
        end else begin
          s_d.frame = {out_i[dfs_pkg::WORK_W-1 -: RES], {RES{1'b0}}};
          s_d.nbits = NBW'(RES);
          s_d.load = 1'b1;
        end
      end else begin
        s_d.div = s_q.div + 5'h01;
        s_d.acc_i = sum_i;
        s_d.acc_q = sum_q;
      end
    end

    // Bit clock toggles once per lane bit; frame high for first half
    // A frame loaded while busy restarts the count; the old frame is cut
    if (s_q.load) begin
      s_d.fcnt = s_q.nbits;
      s_d.bclk = 1'b1;
      s_d.frame_clock_out = 1'b1;
    end else if (s_q.fcnt != '0) begin
      s_d.fcnt = s_q.fcnt - NBW'(1);
      // Clock parks low in the cycle after the last bit so no stray edge trails the frame
      if (s_q.fcnt == NBW'(1)) begin
        s_d.bclk = 1'b0;
      end else begin
        s_d.bclk = !s_q.bclk;
      end
      s_d.frame_clock_out = (s_q.fcnt - NBW'(1)) > (s_q.nbits >> 1);
    end else begin
      s_d.bclk = 1'b0;
      s_d.frame_clock_out = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.ctrl <= dfs_pkg::CTRL_RST;
      s_q.nco_pend <= dfs_pkg::NCO_RST;
      s_q.nco_act <= dfs_pkg::NCO_RST;
      s_q.div <= dfs_pkg::DIV_RST;
      s_q.sync_cnt <= dfs_pkg::SYNC_CNT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Lanes take frame bits in turn so the word leaves MSB first overall
  genvar gl;
  generate
    for (gl = 0; gl < LANES; gl++) begin : g_lane
      always_comb begin
        lane_word[gl] = '0;
        for (int j = 0; j < LW; j++) begin
          lane_word[gl][LW-1-j] = s_q.frame[FW-1-(j*LANES+gl)];
        end
      end
      dfs_lane #(
        .W(LW),
        .NBW(NBW)
      ) u_lane (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .load_i(s_q.load),
        .word_i(lane_word[gl]),
        .nbits_i(s_q.nbits),
        .bit_o(lane_bit[gl])
      );
    end
  endgenerate

  assign serial_data_lanes_o = lane_bit;
  assign prdata_o = s_q.prdata;
  assign pready_o = s_q.pready;
  assign pslverr_o = s_q.pslverr;
  assign powerdown_o = s_q.pwrdn;
  assign serial_bit_clock_out_o = s_q.bclk;
  assign frame_clock_out_o = s_q.frame_clock_out;

endmodule

/* File: dfs_top_properties.sv */
// Port-level assertions for the decimation and serial output block
`timescale 1ns/10ps
module dfs_top_properties #(
  parameter int RES = 18,
  parameter int LANES = 2
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire dfs_pkg::dfs_apb_req_t apb_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic signed [dfs_pkg::SAMPLE_W-1:0] sample_i,
  input wire logic sample_valid_i,
  input wire logic powerdown_or_sync_pin_i,
  input wire logic powerdown_o,
  input wire logic [LANES-1:0] serial_data_lanes_o,
  input wire logic serial_bit_clock_out_o,
  input wire logic frame_clock_out_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic frame_clock_out_q;
  logic [4:0] cnt_q;
  // Cycles since frame start, parked at the top while idle
  always_ff @(posedge core_clk_i) begin
    frame_clock_out_q <= frame_clock_out_o;
    if (rst_i) begin
      cnt_q <= 5'h1f;
    end else if (frame_clock_out_o && !frame_clock_out_q) begin
      cnt_q <= 5'h01;
    end else if (cnt_q != 5'h1f) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end
  chk_ready_wait: assert property (apb_i.psel && apb_i.penable && !pready_o |=> pready_o)
    else $error("pready late");
  chk_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  chk_slverr_map: assert property (pready_o |-> pslverr_o ==
    !($past(apb_i.paddr) inside {12'h000, 12'h004, 12'h008, 12'h00c}))
    else $error("pslverr does not match address");
  chk_pd_quiet: assert property (!powerdown_or_sync_pin_i [*6] |-> !powerdown_o)
    else $error("powerdown without pin");
  chk_bclk_toggle: assert property ($rose(frame_clock_out_o) |-> serial_bit_clock_out_o
    ##1 !serial_bit_clock_out_o ##16 !serial_bit_clock_out_o)
    else $error("bit clock not half lane rate");
  chk_frame_clock_out_half: assert property ($rose(frame_clock_out_o) |->
    frame_clock_out_o [*8] ##1 frame_clock_out_o ##1 !frame_clock_out_o)
    else $error("frame clock high time wrong");
  chk_lanes_idle: assert property (cnt_q >= 5'h12 && !frame_clock_out_o |->
    serial_data_lanes_o == '0 && !serial_bit_clock_out_o)
    else $error("lanes busy after frame");
  chk_frame_start: assert property ($rose(serial_bit_clock_out_o) && cnt_q >= 5'h12 |->
    frame_clock_out_o)
    else $error("bits without frame clock");
endmodule
bind dfs_top dfs_top_properties #(.RES(RES), .LANES(LANES)) u_dfs_top_properties (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .apb_i(apb_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .sample_i(sample_i),
  .sample_valid_i(sample_valid_i), .powerdown_or_sync_pin_i(powerdown_or_sync_pin_i),
  .powerdown_o(powerdown_o), .serial_data_lanes_o(serial_data_lanes_o),
  .serial_bit_clock_out_o(serial_bit_clock_out_o), .frame_clock_out_o(frame_clock_out_o));

/* File: dfs_top_tb.sv */
// Self-checking bench for the decimation and serial output block
`timescale 1ns/10ps
module dfs_top_tb;
  typedef struct {logic [35:0] m; logic [35:0] v; int p;} dfs_exp_t;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  dfs_pkg::dfs_apb_req_t apb_i = '0;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, powerdown_o, bclk, frame_clock_out, word_valid;
  logic signed [17:0] sample_i = '0;
  logic sample_valid_i = 1'b0;
  logic pin = 1'b0;
  logic [1:0] lanes;
  logic [35:0] word;
  int period, cyc = 0, syncs = 0, num_errors = 0, samples_checked = 0;
  logic [32:0] rq[$];
  dfs_exp_t fq[$];
  dfs_top u_dfs_top (.core_clk_i(core_clk_i), .rst_i(rst_i), .apb_i(apb_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .sample_i(sample_i),
    .sample_valid_i(sample_valid_i), .powerdown_or_sync_pin_i(pin), .powerdown_o(powerdown_o),
    .serial_data_lanes_o(lanes), .serial_bit_clock_out_o(bclk), .frame_clock_out_o(frame_clock_out));
  dfs_rx_model u_dfs_rx_model (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .serial_data_lanes_i(lanes), .frame_clock_i(frame_clock_out), .word_o(word),
    .word_valid_o(word_valid), .period_o(period));
  initial forever #2.5 core_clk_i = ~core_clk_i;
  task automatic fail(input string msg);
    num_errors++;
    $display("Error at %0t: %s", $time, msg);
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Idle cycle after each transfer keeps one assignment per time step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    apb_i <= '{paddr: a, pwrite: w, pwdata: d, psel: 1'b1, penable: 1'b0};
    @(posedge core_clk_i);
    apb_i.penable <= 1'b1;
    do @(posedge core_clk_i); while (pready_o !== 1'b1);
    apb_i <= '0;
    @(posedge core_clk_i);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    rq.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic chk(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) fail("powerdown level");
  endtask
  // Constant sample per run; the average of a steady input is that input
  task automatic run(input logic rl, input logic [2:0] sel, input int k);
    int n;
    int w;
    int lim;
    logic s;
    logic g;
    logic signed [17:0] x;
    logic [17:0] iw;
    n = (2 << ((sel > dfs_pkg::RATIO_SEL_MAX) ? dfs_pkg::RATIO_SEL_MAX : sel)) * (rl ? 2 : 1);
    s = 1'($urandom);
    g = 1'($urandom);
    x = {s, ~s, 16'($urandom)};
    lim = 1 << (dfs_pkg::WORK_W - 1);
    w = 2 * int'(x);
    if (g && rl) w = (w * int'(dfs_pkg::GAIN_3DB_MUL)) >>> dfs_pkg::GAIN_3DB_SHIFT;
    else if (g) w = 2 * w;
    if (w >= lim) w = lim - 1;
    else if (w < -lim) w = -lim;
    iw = 18'(w >>> (dfs_pkg::WORK_W - 18));
    sample_i <= x;
    apb(1'b1, dfs_pkg::OFS_CTRL, {23'h00_0000, 1'b1, 2'h0, g, sel, rl, 1'b1});
    syncs++;
    repeat (2) @(posedge core_clk_i);
    for (int i = 0; i < k; i++) begin
      fq.push_back('{36'hf_ffff_ffff,
        rl ? {iw, iw} : {iw, 18'h0_0000}, i == 0 ? 0 : n * 10});
    end
    repeat (k * n) begin
      sample_valid_i <= 1'b1;
      @(posedge core_clk_i);
      sample_valid_i <= 1'b0;
      repeat (9) @(posedge core_clk_i);
    end
    repeat (40) @(posedge core_clk_i);
    rd(dfs_pkg::OFS_STATUS, {17'h0_0000, 8'(syncs), 8'h00});
  endtask
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail("timeout");
      tally_and_finish;
    end
  end
  always @(posedge core_clk_i) begin
    dfs_exp_t e;
    if (pready_o === 1'b1 && apb_i.pwrite === 1'b0) begin
      samples_checked++;
      if (rq.size() == 0) fail("unexpected read");
      else if ({pslverr_o, prdata_o} !== rq.pop_front()) fail("read data");
    end
    if (word_valid === 1'b1) begin
      samples_checked++;
      if (fq.size() == 0) begin
        fail("unexpected frame");
      end else begin
        e = fq.pop_front();
        if ((word & e.m) !== e.v || (e.p != 0 && period != e.p)) fail("frame");
      end
    end
  end
  initial begin
    void'($urandom(70));
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    rd(dfs_pkg::OFS_CTRL, 33'h0_0000_0000);
    rd(dfs_pkg::OFS_NCO_ACTIVE, 33'h0_0000_0000);
    rd(dfs_pkg::OFS_STATUS, 33'h0_0000_0000);
    rd(12'h010, 33'h1_0000_0000);
    apb(1'b1, dfs_pkg::OFS_NCO_FREQ, 32'hffff_ffff);
    rd(dfs_pkg::OFS_NCO_FREQ, 33'h0_ffff_ffff);
    rd(dfs_pkg::OFS_NCO_ACTIVE, 33'h0_0000_0000);
    apb(1'b1, dfs_pkg::OFS_CTRL, 32'h0000_0201);
    rd(dfs_pkg::OFS_CTRL, 33'h0_0000_0001);
    rd(dfs_pkg::OFS_NCO_ACTIVE, 33'h0_ffff_ffff);
    apb(1'b1, dfs_pkg::OFS_NCO_FREQ, 32'h0000_0000);
    apb(1'b1, dfs_pkg::OFS_CTRL, 32'h0000_0041);
    pin <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    chk(powerdown_o, 1'b0);
    pin <= 1'b0;
    repeat (8) @(posedge core_clk_i);
    syncs++;
    rd(dfs_pkg::OFS_NCO_ACTIVE, 33'h0_0000_0000);
    rd(dfs_pkg::OFS_STATUS, {17'h0_0000, 8'(syncs), 8'h00});
    apb(1'b1, dfs_pkg::OFS_CTRL, 32'h0000_0001);
    pin <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    chk(powerdown_o, 1'b1);
    pin <= 1'b0;
    repeat (8) @(posedge core_clk_i);
    rd(dfs_pkg::OFS_STATUS, {17'h0_0000, 8'(syncs), 8'h00});
    for (int i = 0; i < 5; i++) run(1'b0, 3'(i), 3);
    for (int i = 0; i < 5; i++) run(1'b1, 3'(i), 2);
    run(1'b0, 3'h6, 2);
    tally_and_finish;
  end
endmodule
